// [pkg/tcd_pkg.sv]
// What this block does
// - two channels steal bus cycles, priority over the processor
// - request comes from software trigger or selected interrupt, ignoring cpu masks
// - transfers never touch any interrupt source or pending state
// - enabled channel starts one unit per request
// - requests arriving before service merge into one pending request
// - any-to-fixed, fixed-to-any, fixed-to-fixed; own register region 0x20-0x3F unreachable
// - 8 or 16 bit units, 16-bit unit counter
// - selectable sources: ext pin edges, peripheral irqs, software trigger
// - channel zero wins over channel one on simultaneous requests
// - source and destination never both incrementing
// - single mode: underflow clears enable
// - repeat mode: underflow reloads counter, channel stays active
// - completion interrupt pulses on counter underflow
// - enable written zero stops new transfers
// - first transfer after activation loads forward pointer and counter
// - forward pointer always writable, fixed pointer only while disabled
// - after the first transfer of an enabled channel, forward pointer register reads the live forward pointer
// - writing one to enable of active channel restarts it
// - request bit sets always, clears at start, software writes only zero
// - bus returns to processor between channel zero and channel one transfers
// - odd-address 16-bit unit takes two reads at an odd source and two writes at an odd destination
package tcd_pkg;
	localparam int         ADDR_W    = 20;
	localparam logic [7:0] OFS_SRC   = 8'h00;
	localparam logic [7:0] OFS_DST   = 8'h04;
	localparam logic [7:0] OFS_RLD   = 8'h08;
	localparam logic [7:0] OFS_CTL   = 8'h0C;
	localparam logic [7:0] OFS_CNT   = 8'h10;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam int         B_EN      = 0;
	localparam int         B_REQ     = 1;
	localparam int         B_U8      = 2;
	localparam int         B_RPT     = 3;
	localparam int         B_SFW     = 4;
	localparam int         B_DFW     = 5;
	localparam int         B_SWT     = 6;
	localparam int         B_SEL     = 8;
	localparam int         SEL_W     = 5;
	localparam logic [19:0] PROT_LO  = 20'h0_0020;
	localparam logic [19:0] PROT_HI  = 20'h0_003F;
	localparam logic [4:0] SEL_SW    = 5'h00;
	localparam logic [4:0] SEL_FALL  = 5'h01;
	localparam logic [4:0] SEL_BOTH  = 5'h02;
	localparam logic [4:0] SEL_IRQ0  = 5'h03;
	localparam logic       RST_PIN   = 1'b1;
	typedef enum logic [2:0] {X_IDLE, X_WAIT, X_RD, X_CAP, X_WR, X_GAP} tcd_xst_t;
endpackage : tcd_pkg

// [pkg/tcd_xfer_if.sv]
`timescale 1ns/1ps
// one-unit transfer order from the register side to the bus engine
interface tcd_xfer_if import tcd_pkg::*; ();
	logic              start;
	logic              ch;
	logic              u16;
	logic [ADDR_W-1:0] src;
	logic [ADDR_W-1:0] dst;
	logic              busy;
	logic              done;
	logic              done_ch;
	modport ctl (output start, ch, u16, src, dst, input busy, done, done_ch);
	modport eng (input start, ch, u16, src, dst, output busy, done, done_ch);
endinterface : tcd_xfer_if

// [rtl/tcd_reqsel.sv]
`timescale 1ns/1ps
module tcd_reqsel import tcd_pkg::*; #(
	parameter int NUM_IRQ = 20
) (
	input  wire logic               i_mclk,
	input  wire logic               i_srst,
	input  wire logic [SEL_W-1:0]   i_sel,
	input  wire logic               i_pin,
	input  wire logic               i_sw,
	input  wire logic [NUM_IRQ-1:0] i_irq,
	output logic                    o_req
);
	typedef struct packed {
		logic pin_d;
	} tcd_rs_st_t;
	localparam logic [5:0] NIRQ = 6'(NUM_IRQ);
	tcd_rs_st_t r, n;
	logic [4:0] idx;

	if (NUM_IRQ < 1 || NUM_IRQ > 29) begin : g_chk
		$error("NUM_IRQ must be 1 to 29");
	end

	// previous pin level for edge detection
	always_comb begin
		n = r;
		n.pin_d = i_pin;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			r <= '0;
			r.pin_d <= RST_PIN;
		end else begin
			r <= n;
		end
	end

	// source select; interrupt lines are only observed, never acknowledged
	assign idx = i_sel - SEL_IRQ0;
	always_comb begin
		case (i_sel)
			SEL_SW:   o_req = i_sw;
			SEL_FALL: o_req = r.pin_d & ~i_pin;
			SEL_BOTH: o_req = r.pin_d ^ i_pin;
			default:  o_req = ({1'b0, idx} < NIRQ) ? i_irq[idx] : 1'b0;
		endcase
	end
endmodule : tcd_reqsel

// [rtl/tcd_xfer.sv]
`timescale 1ns/1ps
module tcd_xfer import tcd_pkg::*; (
	input  wire logic              i_mclk,
	input  wire logic              i_srst,
	tcd_xfer_if.eng                x,
	input  wire logic              i_bus_gnt,
	input  wire logic [15:0]       i_bus_rdata,
	output logic                   o_bus_req,
	output logic                   o_bus_rd,
	output logic                   o_bus_wr,
	output logic                   o_bus_byte,
	output logic [ADDR_W-1:0]      o_bus_addr,
	output logic [15:0]            o_bus_wdata
);
	typedef struct packed {
		tcd_xst_t          st;
		logic              ch;
		logic              u16;
		logic              ph;
		logic              req;
		logic              rd;
		logic              wr;
		logic              byt;
		logic              done;
		logic [ADDR_W-1:0] src;
		logic [ADDR_W-1:0] dst;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       dat;
		logic [15:0]       wd;
	} tcd_xf_st_t;
	tcd_xf_st_t r, n;

	// the block's own register window never gets a bus strobe; data read from it is taken as zero
	function automatic logic prot(input logic [ADDR_W-1:0] a);
		return (a >= PROT_LO) && (a <= PROT_HI);
	endfunction : prot

	// read-then-write sequencer; grant is assumed to hold while request is high
	always_comb begin
		logic        ss;
		logic        sd;
		logic [15:0] rb;
		logic [15:0] wv;
		ss = r.u16 & r.src[0];
		sd = r.u16 & r.dst[0];
		rb = prot(r.addr) ? 16'h0000 : i_bus_rdata;
		wv = 16'h0000;
		n = r;
		n.rd = 1'b0;
		n.wr = 1'b0;
		n.done = 1'b0;
		case (r.st)
			X_IDLE: if (x.start) begin
				n.ch = x.ch;
				n.u16 = x.u16;
				n.src = x.src;
				n.dst = x.dst;
				n.ph = 1'b0;
				n.req = 1'b1;
				n.st = X_WAIT;
			end
			X_WAIT: if (i_bus_gnt) begin
				n.addr = r.src;
				n.byt = ~r.u16 | r.src[0];
				n.rd = ~prot(r.src);
				n.st = X_RD;
			end
			X_RD: n.st = X_CAP;
			X_CAP: begin
				if (ss && !r.ph) begin
					n.dat[7:0] = rb[7:0];
					n.ph = 1'b1;
					n.addr = r.src + 20'h0_0001;
					n.rd = ~prot(r.src + 20'h0_0001);
					n.st = X_RD;
				end else begin
					if (ss)
						wv = {rb[7:0], r.dat[7:0]};
					else if (r.u16)
						wv = rb;
					else
						wv = {8'h00, rb[7:0]};
					n.dat = wv;
					n.ph = 1'b0;
					n.addr = r.dst;
					n.byt = ~r.u16 | r.dst[0];
					n.wd = sd ? {8'h00, wv[7:0]} : wv;
					n.wr = ~prot(r.dst);
					n.st = X_WR;
				end
			end
			X_WR: begin
				if (sd && !r.ph) begin
					n.ph = 1'b1;
					n.addr = r.dst + 20'h0_0001;
					n.wd = {8'h00, r.dat[15:8]};
					n.wr = ~prot(r.dst + 20'h0_0001);
				end else begin
					n.req = 1'b0;
					n.done = 1'b1;
					n.st = X_GAP;
				end
			end
			// request stays low here so the processor gets its access
			X_GAP: n.st = X_IDLE;
			default: n.st = X_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			r <= '0;
			r.st <= X_IDLE;
		end else begin
			r <= n;
		end
	end

	assign o_bus_req = r.req;
	assign o_bus_rd = r.rd;
	assign o_bus_wr = r.wr;
	assign o_bus_byte = r.byt;
	assign o_bus_addr = r.addr;
	assign o_bus_wdata = r.wd;
	assign x.busy = (r.st != X_IDLE);
	assign x.done = r.done;
	assign x.done_ch = r.ch;
endmodule : tcd_xfer

// [rtl/tcd_top.sv]
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module tcd_top import tcd_pkg::*; #(
	parameter int NUM_IRQ = 20
) (
	input  wire logic               i_mclk,
	input  wire logic               i_srst,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic [31:0]             o_rdata,
	input  wire logic               i_ext_irq_pin_a,
	input  wire logic               i_ext_irq_pin_b,
	input  wire logic [NUM_IRQ-1:0] i_irq,
	input  wire logic               i_bus_gnt,
	input  wire logic [15:0]        i_bus_rdata,
	output logic                    o_bus_req,
	output logic                    o_bus_rd,
	output logic                    o_bus_wr,
	output logic                    o_bus_byte,
	output logic [ADDR_W-1:0]       o_bus_addr,
	output logic [15:0]             o_bus_wdata,
	output logic [1:0]              o_done_irq
);
	typedef struct packed {
		logic [1:0][ADDR_W-1:0] src;
		logic [1:0][ADDR_W-1:0] dst;
		logic [1:0][ADDR_W-1:0] fptr;
		logic [1:0][15:0]       rld;
		logic [1:0][15:0]       cnt;
		logic [1:0][SEL_W-1:0]  sel;
		logic [1:0]             en;
		logic [1:0]             fresh;
		logic [1:0]             req;
		logic [1:0]             u8;
		logic [1:0]             rpt;
		logic [1:0]             sfw;
		logic [1:0]             dfw;
		logic [1:0]             irq;
		logic [31:0]            rdata;
	} tcd_top_st_t;
	tcd_top_st_t r, n;
	tcd_xfer_if x ();
	logic [1:0]        rq;
	logic [1:0]        swt;
	logic [1:0]        dfe;
	logic              go0;
	logic              go1;
	logic              c;
	logic [ADDR_W-1:0] ptr;

	// byte address of a channel register
	function automatic logic [7:0] ra(input logic ch, input logic [7:0] ofs);
		return (ch ? CH_STRIDE : 8'h00) + ofs;
	endfunction : ra

	// one request selector per channel, pin a feeds channel zero
	for (genvar g = 0; g < 2; g++) begin : g_ch
		assign swt[g] = i_wr && (i_addr == ra(1'(g), OFS_CTL)) && i_wdata[B_SWT];
		assign dfe[g] = r.dfw[g] & ~r.sfw[g];
		tcd_reqsel #(
			.NUM_IRQ (NUM_IRQ)
		) u_sel (
			.i_mclk  (i_mclk),
			.i_srst  (i_srst),
			.i_sel   (r.sel[g]),
			.i_pin   (g == 0 ? i_ext_irq_pin_a : i_ext_irq_pin_b),
			.i_sw    (swt[g]),
			.i_irq   (i_irq),
			.o_req   (rq[g])
		);
	end

	// fixed priority, one order per idle engine
	assign go0 = r.en[0] & r.req[0];
	assign go1 = r.en[1] & r.req[1];
	assign c = ~go0;
	assign ptr = r.fresh[c] ? (r.sfw[c] ? r.src[c] : r.dst[c]) : r.fptr[c];
	assign x.start = ~x.busy & (go0 | go1);
	assign x.ch = c;
	assign x.u16 = ~r.u8[c];
	assign x.src = r.sfw[c] ? ptr : r.src[c];
	assign x.dst = dfe[c] ? ptr : r.dst[c];

	tcd_xfer u_xfer (
		.i_mclk      (i_mclk),
		.i_srst      (i_srst),
		.x           (x.eng),
		.i_bus_gnt   (i_bus_gnt),
		.i_bus_rdata (i_bus_rdata),
		.o_bus_req   (o_bus_req),
		.o_bus_rd    (o_bus_rd),
		.o_bus_wr    (o_bus_wr),
		.o_bus_byte  (o_bus_byte),
		.o_bus_addr  (o_bus_addr),
		.o_bus_wdata (o_bus_wdata)
	);

	// per channel: completion, start, software writes, request set, read
	always_comb begin
		n = r;
		n.rdata = 32'h0000_0000;
		n.irq = 2'b00;
		for (int i = 0; i < 2; i++) begin
			if (x.done && (x.done_ch == 1'(i))) begin
				n.fptr[i] = r.fptr[i] + (r.u8[i] ? 20'h0_0001 : 20'h0_0002);
				if (r.cnt[i] == 16'h0000) begin
					n.irq[i] = 1'b1;
					if (r.rpt[i])
						n.cnt[i] = r.rld[i];
					else
						n.en[i] = 1'b0;
				end else begin
					n.cnt[i] = r.cnt[i] - 16'h0001;
				end
			end
			if (x.start && (c == 1'(i))) begin
				n.req[i] = 1'b0;
				if (r.fresh[i]) begin
					n.fptr[i] = ptr;
					n.cnt[i] = r.rld[i];
					n.fresh[i] = 1'b0;
				end
			end
			if (i_wr) begin
				// a fixed pointer cannot move under a running channel
				if (i_addr == ra(1'(i), OFS_SRC) && (r.sfw[i] || !r.en[i]))
					n.src[i] = i_wdata[ADDR_W-1:0];
				if (i_addr == ra(1'(i), OFS_DST) && (dfe[i] || !r.en[i]))
					n.dst[i] = i_wdata[ADDR_W-1:0];
				if (i_addr == ra(1'(i), OFS_RLD))
					n.rld[i] = i_wdata[15:0];
				if (i_addr == ra(1'(i), OFS_CTL)) begin
					n.en[i] = i_wdata[B_EN];
					if (i_wdata[B_EN])
						n.fresh[i] = 1'b1;
					if (!i_wdata[B_REQ])
						n.req[i] = 1'b0;
					n.u8[i] = i_wdata[B_U8];
					n.rpt[i] = i_wdata[B_RPT];
					n.sfw[i] = i_wdata[B_SFW];
					n.dfw[i] = i_wdata[B_DFW];
					n.sel[i] = i_wdata[B_SEL +: SEL_W];
				end
			end
			// a new request wins over any clear and merges with a pending one
			if (rq[i])
				n.req[i] = 1'b1;
			if (i_rd) begin
				if (i_addr == ra(1'(i), OFS_SRC))
					n.rdata = {12'h000, (r.en[i] && !r.fresh[i] && r.sfw[i]) ?
						r.fptr[i] : r.src[i]};
				if (i_addr == ra(1'(i), OFS_DST))
					n.rdata = {12'h000, (r.en[i] && !r.fresh[i] && dfe[i]) ?
						r.fptr[i] : r.dst[i]};
				if (i_addr == ra(1'(i), OFS_RLD))
					n.rdata = {16'h0000, r.rld[i]};
				if (i_addr == ra(1'(i), OFS_CNT))
					n.rdata = {16'h0000, r.cnt[i]};
				if (i_addr == ra(1'(i), OFS_CTL))
					n.rdata = {19'h0_0000, r.sel[i], 2'b00, r.dfw[i], r.sfw[i],
						r.rpt[i], r.u8[i], r.req[i], r.en[i]};
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst)
			r <= '0;
		else
			r <= n;
	end

	assign o_rdata = r.rdata;
	assign o_done_irq = r.irq;
endmodule : tcd_top

// [tb/tcd_checker.sv]
`timescale 1ns/1ps
// watches bus and register read ports of the top
module tcd_checker import tcd_pkg::*; (
	input wire logic              i_mclk,
	input wire logic              i_srst,
	input wire logic              i_rd,
	input wire logic [31:0]       o_rdata,
	input wire logic              i_bus_gnt,
	input wire logic              o_bus_req,
	input wire logic              o_bus_rd,
	input wire logic              o_bus_wr,
	input wire logic              o_bus_byte,
	input wire logic [ADDR_W-1:0] o_bus_addr,
	input wire logic [1:0]        o_done_irq
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// strobes only inside a bus tenure, after grant, one at a time
	strobe_own_a: assert property ((o_bus_rd || o_bus_wr) |-> o_bus_req)
		else $error("bus strobe outside request");
	gnt_first_a: assert property (o_bus_req && !i_bus_gnt |=> !o_bus_rd && !o_bus_wr)
		else $error("bus strobe without grant");
	one_strobe_a: assert property (!(o_bus_rd && o_bus_wr))
		else $error("read and write strobe together");
	// no read or write strobe ever goes to the own register window
	prot_hole_a: assert property ((o_bus_rd || o_bus_wr) |->
		!(o_bus_addr inside {[PROT_LO:PROT_HI]}))
		else $error("access into protected window");
	// the processor gets the bus back between units
	req_gap_a: assert property ($fell(o_bus_req) |-> !o_bus_req [*2])
		else $error("bus not returned between units");
	done_pulse_a: assert property (o_done_irq != 2'b00 |=> o_done_irq == 2'b00)
		else $error("completion pulse too long");
	done_cause_a: assert property (o_done_irq != 2'b00 |->
		!$past(o_bus_req) && $past(o_bus_req, 2))
		else $error("completion pulse without unit end");
	word_even_a: assert property (o_bus_rd && !o_bus_byte |-> !o_bus_addr[0])
		else $error("word access at odd address");
	// a write to an odd destination address must be a byte write
	wr_even_a: assert property (o_bus_wr && !o_bus_byte |-> !o_bus_addr[0])
		else $error("word write at odd address");
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	cover property (o_done_irq[0]);
	cover property (o_done_irq[1]);
	cover property (o_bus_wr && o_bus_byte);
	cover property (o_bus_wr && o_bus_addr[0]);
endmodule : tcd_checker

bind tcd_top tcd_checker i_tcd_checker (.i_mclk(i_mclk), .i_srst(i_srst), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_bus_gnt(i_bus_gnt), .o_bus_req(o_bus_req), .o_bus_rd(o_bus_rd),
	.o_bus_wr(o_bus_wr), .o_bus_byte(o_bus_byte), .o_bus_addr(o_bus_addr),
	.o_done_irq(o_done_irq));

// [tb/tcd_mem.sv]
`timescale 1ns/1ps
// processor and memory: grants after a lag, answers reads, logs writes
module tcd_mem import tcd_pkg::*; (
	input  wire logic              i_mclk,
	input  wire logic              i_srst,
	input  wire logic              i_req,
	input  wire logic              i_rd,
	input  wire logic              i_wr,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [15:0]       i_wdata,
	output logic                   o_gnt,
	output logic [15:0]            o_rdata
);
	int                lag = 2;
	int                cnt = 0;
	int                wc;
	int                rc;
	logic [ADDR_W-1:0] wa;
	logic [15:0]       wd;
	// stale read data flips each cycle so a late sample never matches
	always @(posedge i_mclk) begin
		cnt <= i_req ? cnt + 1 : 0;
		o_gnt <= i_req && !i_srst && cnt >= lag;
		o_rdata <= i_rd ? {i_addr[7:0] ^ 8'h3C, i_addr[7:0]} : ~o_rdata;
		if (i_wr) begin
			wc <= wc + 1;
			wa <= i_addr;
			wd <= i_wdata;
		end
		if (i_rd) rc <= rc + 1;
		if (i_srst) begin
			wc <= 0;
			rc <= 0;
			o_rdata <= 16'hA5A5;
		end
	end
endmodule : tcd_mem

// [tb/tcd_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tcd_tb_top;
	import tcd_pkg::*;
	logic              clk = 0, srst = 1, wr = 0, rd = 0, pa = 1, pb = 1;
	logic [7:0]        addr = 0;
	logic [31:0]       wdata = 0, rdata;
	logic [19:0]       irq = 0;
	logic              gnt, req, brd, bwr, bbyte;
	logic [ADDR_W-1:0] baddr;
	logic [15:0]       bwd, brdat;
	logic [1:0]        dirq;
	int                miscompares = 0, check_count = 0, ic0 = 0, ic1 = 0, n, m, k;
	tcd_top i_tcd_top (.i_mclk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin_a(pa), .i_ext_irq_pin_b(pb),
		.i_irq(irq), .i_bus_gnt(gnt), .i_bus_rdata(brdat), .o_bus_req(req), .o_bus_rd(brd),
		.o_bus_wr(bwr), .o_bus_byte(bbyte), .o_bus_addr(baddr), .o_bus_wdata(bwd),
		.o_done_irq(dirq));
	tcd_mem i_tcd_mem (.i_mclk(clk), .i_srst(srst), .i_req(req), .i_rd(brd), .i_wr(bwr),
		.i_addr(baddr), .i_wdata(bwd), .o_gnt(gnt), .o_rdata(brdat));
	initial forever #50 clk = ~clk;
	// completion pulses last one cycle, so count them as they pass
	always @(posedge clk) begin
		if (dirq[0] === 1'b1) ic0++;
		if (dirq[1] === 1'b1) ic1++;
	end
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1;
		`CHK(rdata, e)
	endtask : r
	task automatic p(input int b);
		@(posedge clk);
		irq[b] <= 1;
		@(posedge clk);
		irq[b] <= 0;
	endtask : p
	// wait for the model to log t writes, bounded
	task automatic ww(input int t);
		for (int i = 0; i < 300; i++) begin
			if (i_tcd_mem.wc >= t) return;
			@(posedge clk);
			#1;
		end
		miscompares++;
		stop_test();
	endtask : ww
	// select written twice with enable low clears a request raised by the select change
	task automatic cfg(input logic [7:0] b, input logic [19:0] s, d, input logic [15:0] rl,
		input logic [31:0] c);
		w(b + OFS_SRC, s);
		w(b + OFS_DST, d);
		w(b + OFS_RLD, rl);
		w(b + OFS_CTL, c & 32'h1F00);
		w(b + OFS_CTL, c & 32'h1F00);
		n = i_tcd_mem.wc;
		m = i_tcd_mem.rc;
		k = ic0;
		w(b + OFS_CTL, c);
	endtask : cfg
	task automatic t_single();
		cfg(0, 12'h100, 12'h200, 1, 12'h321);
		p(0);
		ww(n + 1);
		`CHK(i_tcd_mem.wa, 12'h200)
		`CHK(i_tcd_mem.wd, 16'h3C00)
		w(OFS_SRC, 12'h180);
		r(OFS_SRC, 12'h100);
		r(OFS_DST, 12'h202);
		r(OFS_CNT, 0);
		`CHK(ic0, k)
		w(OFS_CTL, 12'h321);
		p(0);
		ww(n + 2);
		`CHK(i_tcd_mem.wa, 12'h200)
		p(0);
		ww(n + 3);
		`CHK(i_tcd_mem.wa, 12'h202)
		repeat (4) @(posedge clk);
		`CHK(ic0, k + 1)
		r(OFS_CTL, 12'h320);
	endtask : t_single
	task automatic t_reqbit();
		cfg(0, 12'h100, 12'h300, 0, 0);
		w(OFS_CTL, 2);
		r(OFS_CTL, 0);
		w(OFS_CTL, 8'h40);
		repeat (6) @(posedge clk);
		`CHK(i_tcd_mem.wc, n)
		r(OFS_CTL, 2);
		w(OFS_CTL, 0);
		r(OFS_CTL, 0);
	endtask : t_reqbit
	// one software-triggered unit between fixed addresses, nr reads and nw writes expected
	task automatic run(input logic [19:0] s, dd, input logic [7:0] c, input logic [15:0] mk, d,
		input int nr, nw);
		cfg(0, s, dd, 0, c | 8'h41);
		ww(n + nw);
		`CHK(i_tcd_mem.wd & mk, d)
		`CHK(i_tcd_mem.rc - m, nr)
		`CHK(i_tcd_mem.wc - n, nw)
		`CHK(i_tcd_mem.wa, dd + nw - 1)
		repeat (4) @(posedge clk);
	endtask : run
	task automatic t_repeat();
		i_tcd_mem.lag = 4;
		cfg(8'h20, 12'h400, 12'h310, 0, 12'h519);
		k = ic1;
		repeat (4) p(2);
		ww(n + 2);
		repeat (12) @(posedge clk);
		`CHK(i_tcd_mem.wc, n + 2)
		`CHK(ic1, k + 2)
		r(8'h2C, 12'h519);
		r(8'h20, 12'h404);
		w(8'h2C, 0);
		i_tcd_mem.lag = 0;
	endtask : t_repeat
	task automatic t_prio();
		cfg(8'h20, 12'h100, 12'h600, 0, 12'h101);
		cfg(0, 12'h100, 12'h500, 0, 12'h101);
		@(posedge clk);
		pa <= 0;
		pb <= 0;
		ww(n + 1);
		`CHK(i_tcd_mem.wa, 12'h500)
		ww(n + 2);
		`CHK(i_tcd_mem.wa, 12'h600)
		pa <= 1;
		pb <= 1;
	endtask : t_prio
	initial begin
		repeat (4) @(posedge clk);
		srst <= 0;
		t_single();
		t_reqbit();
		run(12'h101, 12'h300, 0, 16'hFFFF, 16'h0201, 2, 1);
		run(12'h102, 12'h301, 0, 16'hFFFF, 16'h003E, 1, 2);
		run(12'h105, 12'h300, 4, 16'h00FF, 16'h0005, 1, 1);
		run(12'h030, 12'h300, 0, 16'hFFFF, 16'h0000, 0, 1);
		t_repeat();
		t_prio();
		stop_test();
	end
endmodule : tcd_tb_top
